// >>> icr_pkg.sv
package icr_pkg;

  // Bus geometry
  localparam int          AXI_ADDR_W   = 12;
  localparam int          DATA_W       = 32;
  localparam int          STRB_W       = 4;
  localparam int          REG_NUM      = 7;
  localparam int          IDX_W        = 3;

  // Register byte offsets
  localparam logic [11:0] OFF_PREV_PTR = 12'h000;
  localparam logic [11:0] OFF_CODEC    = 12'h004;
  localparam logic [11:0] OFF_Y2R_A    = 12'h008;
  localparam logic [11:0] OFF_Y2R_B    = 12'h00C;
  localparam logic [11:0] OFF_R2Y_A    = 12'h010;
  localparam logic [11:0] OFF_R2Y_B    = 12'h014;
  localparam logic [11:0] OFF_R2Y_C    = 12'h018;

  // Register indices (offset divided by four)
  localparam logic [2:0]  IDX_PREV     = 3'h0;
  localparam logic [2:0]  IDX_CODEC    = 3'h1;
  localparam logic [2:0]  IDX_Y2R_A    = 3'h2;
  localparam logic [2:0]  IDX_Y2R_B    = 3'h3;
  localparam logic [2:0]  IDX_R2Y_A    = 3'h4;
  localparam logic [2:0]  IDX_R2Y_B    = 3'h5;
  localparam logic [2:0]  IDX_R2Y_C    = 3'h6;

  // Writable bit masks; reserved bits read as zero
  localparam logic [31:0] MASK_FULL    = 32'hFFFFFFFF;
  localparam logic [31:0] MASK_PTR     = 32'hFFFFFFFC;
  localparam logic [31:0] MASK_Y2R_B   = 32'h000071FF;
  localparam logic [31:0] MASK_R2Y     = 32'h01FFFFFF;
  localparam logic [31:0] RST_ZERO     = 32'h00000000;

  // Field positions
  localparam int          COEF_W       = 8;
  localparam int          Y2R_C4_W     = 9;
  localparam int          Y2R_C4_LSB   = 0;
  localparam int          Y2R_YOFF_BIT = 12;
  localparam int          Y2R_CROFF_BIT = 13;
  localparam int          Y2R_CBOFF_BIT = 14;
  localparam int          R2Y_OFF_BIT  = 24;
  localparam int          R2Y_COEF_BITS = 24;

  // Offset magnitudes applied by the conversion datapath
  localparam logic [7:0]  OFS_128      = 8'h80;
  localparam logic [7:0]  OFS_16       = 8'h10;
  localparam logic [7:0]  OFS_NONE     = 8'h00;

  // AXI answers
  localparam logic [3:0]  STRB_ALL     = 4'hF;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage

// >>> icr_reg_if.sv
`timescale 1ns/100ps
interface icr_reg_if;
  import icr_pkg::*;
  logic                  wr_en;
  logic [AXI_ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0]     wr_data;
  logic [STRB_W-1:0]     wr_strb;
  logic                  wr_err;
  logic [AXI_ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0]     rd_data;
  logic                  rd_err;

  modport front (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 input  wr_err, rd_data, rd_err);
  modport bank  (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 output wr_err, rd_data, rd_err);
endinterface

// >>> icr_axil_slave.sv
`timescale 1ns/100ps
module icr_axil_slave
  import icr_pkg::*;
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Write address and data
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [DATA_W-1:0]     wdata,
  input  wire logic [STRB_W-1:0]     wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  // Write response
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  // Read
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [DATA_W-1:0]          rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  // Register bank side
  icr_reg_if.front                   bus
);

  logic                  awready_q;
  logic                  wready_q;
  logic                  aw_hold_q;
  logic                  w_hold_q;
  logic [AXI_ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0]     wdata_q;
  logic [STRB_W-1:0]     wstrb_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  arready_q;
  logic                  rvalid_q;
  logic [1:0]            rresp_q;
  logic [DATA_W-1:0]     rdata_q;
  logic                  wr_fire;

  // The write goes to the bank once both halves are held; ready stays low
  // until the response is taken, so one write at a time is in flight
  assign wr_fire      = aw_hold_q && w_hold_q && !bvalid_q;
  assign bus.wr_en    = wr_fire;
  assign bus.wr_addr  = awaddr_q;
  assign bus.wr_data  = wdata_q;
  assign bus.wr_strb  = wstrb_q;
  assign bus.rd_addr  = araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      aw_hold_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_hold_q <= 1'b1;
      awaddr_q  <= awaddr;
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end else if (bvalid_q && bready) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      w_hold_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_hold_q <= 1'b1;
      wdata_q  <= wdata;
      wstrb_q  <= wstrb;
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end else if (bvalid_q && bready) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= bus.wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read data is sampled in the address cycle, so it is the value that
  // stood when the request was taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= bus.rd_err ? RESP_SLVERR : RESP_OKAY;
      rdata_q   <= bus.rd_data;
    end else if (rvalid_q && rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;

endmodule

// >>> icr_config_regs.sv
`timescale 1ns/100ps
module icr_config_regs
  import icr_pkg::*;
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [DATA_W-1:0]     s_axi_wdata,
  input  wire logic [STRB_W-1:0]     s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [DATA_W-1:0]          s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Preview DMA progress
  input  wire logic                  preview_ptr_update,
  input  wire logic [DATA_W-1:0]     preview_ptr_next,
  // Preview and codec DMA configuration
  output logic [DATA_W-1:0]          preview_queue_start,
  output logic                       preview_queue_reload,
  output logic [DATA_W-1:0]          codec_dma_base,
  // YCrCb to RGB matrix
  output logic [3:0][COEF_W-1:0]     y2r_coef,
  output logic [Y2R_C4_W-1:0]        y2r_coef4,
  output logic [7:0]                 y2r_y_offset,
  output logic [7:0]                 y2r_cr_offset,
  output logic [7:0]                 y2r_cb_offset,
  // RGB to YCrCb matrix
  output logic [8:0][COEF_W-1:0]     r2y_coef,
  output logic [7:0]                 r2y_r_offset,
  output logic [7:0]                 r2y_g_offset,
  output logic [7:0]                 r2y_b_offset
);

  icr_reg_if reg_bus ();

  icr_axil_slave u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .bus     (reg_bus.front)
  );

  // Returns {hit, index}; only aligned words inside the map hit
  function automatic logic [IDX_W:0] decode(input logic [AXI_ADDR_W-1:0] a);
    logic [AXI_ADDR_W-3:0] word;
    word = a[AXI_ADDR_W-1:2];
    if (a[1:0] == 2'h0 && word < (AXI_ADDR_W-2)'(REG_NUM)) begin
      decode = {1'b1, word[IDX_W-1:0]};
    end else begin
      decode = '0;
    end
  endfunction

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] nw,
                                              input logic [STRB_W-1:0] strb);
    merge = old;
    for (int b = 0; b < STRB_W; b++) begin
      if (strb[b]) begin
        merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  function automatic logic [DATA_W-1:0] reg_mask(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_PREV:  reg_mask = MASK_PTR;
      IDX_Y2R_B: reg_mask = MASK_Y2R_B;
      IDX_R2Y_A: reg_mask = MASK_R2Y;
      IDX_R2Y_B: reg_mask = MASK_R2Y;
      IDX_R2Y_C: reg_mask = MASK_R2Y;
      default:   reg_mask = MASK_FULL;
    endcase
  endfunction

  logic              whit;
  logic [IDX_W-1:0]  widx;
  logic              rhit;
  logic [IDX_W-1:0]  ridx;
  logic              wr_go;
  logic [DATA_W-1:0] cfg_q [1:REG_NUM-1];
  logic [DATA_W-1:0] prev_start_q;
  logic [DATA_W-1:0] prev_cur_q;
  logic              prev_reload_q;
  logic [DATA_W-1:0] prev_wr_val;
  logic [7:0]        y_off_q;
  logic [7:0]        cr_off_q;
  logic [7:0]        cb_off_q;
  logic [7:0]        r_off_q;
  logic [7:0]        g_off_q;
  logic [7:0]        b_off_q;
  logic [DATA_W-1:0] rd_mux;

  assign {whit, widx}   = decode(reg_bus.wr_addr);
  assign {rhit, ridx}   = decode(reg_bus.rd_addr);
  assign wr_go          = reg_bus.wr_en && whit;
  assign reg_bus.wr_err = !whit;
  assign reg_bus.rd_err = !rhit;

  // Plain storage registers; reserved bits are masked off on the way in
  generate
    for (genvar i = 1; i < REG_NUM; i++) begin : g_cfg
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cfg_q[i] <= RST_ZERO;
        end else if (wr_go && widx == IDX_W'(i)) begin
          cfg_q[i] <= merge(cfg_q[i], reg_bus.wr_data, reg_bus.wr_strb)
                      & reg_mask(IDX_W'(i));
        end
      end
    end
  endgenerate

  // A partial write merges into the last start address, not the live pointer
  assign prev_wr_val = merge(prev_start_q, reg_bus.wr_data, reg_bus.wr_strb) & MASK_PTR;

  // Software reload beats a DMA step in the same cycle: the new queue wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_start_q  <= RST_ZERO;
      prev_cur_q    <= RST_ZERO;
      prev_reload_q <= 1'b0;
    end else if (wr_go && widx == IDX_PREV) begin
      prev_start_q  <= prev_wr_val;
      prev_cur_q    <= prev_wr_val;
      prev_reload_q <= 1'b1;
    end else begin
      prev_reload_q <= 1'b0;
      if (preview_ptr_update) begin
        prev_cur_q <= preview_ptr_next & MASK_PTR;
      end
    end
  end

  // Offset magnitudes follow their enable bits one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      y_off_q  <= OFS_NONE;
      cr_off_q <= OFS_NONE;
      cb_off_q <= OFS_NONE;
      r_off_q  <= OFS_NONE;
      g_off_q  <= OFS_NONE;
      b_off_q  <= OFS_NONE;
    end else begin
      y_off_q  <= cfg_q[IDX_Y2R_B][Y2R_YOFF_BIT]  ? OFS_128 : OFS_NONE;
      cr_off_q <= cfg_q[IDX_Y2R_B][Y2R_CROFF_BIT] ? OFS_16  : OFS_NONE;
      cb_off_q <= cfg_q[IDX_Y2R_B][Y2R_CBOFF_BIT] ? OFS_16  : OFS_NONE;
      r_off_q  <= cfg_q[IDX_R2Y_A][R2Y_OFF_BIT]   ? OFS_16  : OFS_NONE;
      g_off_q  <= cfg_q[IDX_R2Y_B][R2Y_OFF_BIT]   ? OFS_128 : OFS_NONE;
      b_off_q  <= cfg_q[IDX_R2Y_C][R2Y_OFF_BIT]   ? OFS_128 : OFS_NONE;
    end
  end

  always_comb begin
    rd_mux = RST_ZERO;
    case (ridx)
      IDX_PREV:  rd_mux = prev_cur_q;
      IDX_CODEC: rd_mux = cfg_q[IDX_CODEC];
      IDX_Y2R_A: rd_mux = cfg_q[IDX_Y2R_A];
      IDX_Y2R_B: rd_mux = cfg_q[IDX_Y2R_B];
      IDX_R2Y_A: rd_mux = cfg_q[IDX_R2Y_A];
      IDX_R2Y_B: rd_mux = cfg_q[IDX_R2Y_B];
      IDX_R2Y_C: rd_mux = cfg_q[IDX_R2Y_C];
      default:   rd_mux = RST_ZERO;
    endcase
  end
  assign reg_bus.rd_data = rhit ? rd_mux : RST_ZERO;

  assign preview_queue_start  = prev_start_q;
  assign preview_queue_reload = prev_reload_q;
  assign codec_dma_base       = cfg_q[IDX_CODEC];
  assign y2r_coef             = cfg_q[IDX_Y2R_A];
  assign y2r_coef4            = cfg_q[IDX_Y2R_B][Y2R_C4_LSB +: Y2R_C4_W];
  assign r2y_coef             = {cfg_q[IDX_R2Y_C][R2Y_COEF_BITS-1:0],
                                 cfg_q[IDX_R2Y_B][R2Y_COEF_BITS-1:0],
                                 cfg_q[IDX_R2Y_A][R2Y_COEF_BITS-1:0]};
  assign y2r_y_offset         = y_off_q;
  assign y2r_cr_offset        = cr_off_q;
  assign y2r_cb_offset        = cb_off_q;
  assign r2y_r_offset         = r_off_q;
  assign r2y_g_offset         = g_off_q;
  assign r2y_b_offset         = b_off_q;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic wr_full;
  assign wr_full = wr_go && reg_bus.wr_strb == STRB_ALL;

  ptr_load_a: assert property (
    wr_full && widx == IDX_PREV |=> preview_queue_start == {$past(reg_bus.wr_data[31:2]), 2'h0}
      && preview_queue_reload ##1 !preview_queue_reload)
    else $error("preview pointer write not loaded");

  ptr_follow_a: assert property (
    !(wr_go && widx == IDX_PREV) && preview_ptr_update
      |=> prev_cur_q == {$past(preview_ptr_next[31:2]), 2'h0}
          && $stable(preview_queue_start))
    else $error("preview pointer did not follow the DMA");

  ptr_align_a: assert property (
    rhit && ridx == IDX_PREV |-> reg_bus.rd_data[1:0] == 2'h0
      && preview_queue_start[1:0] == 2'h0)
    else $error("preview pointer not word aligned");

  codec_full_a: assert property (
    wr_full && widx == IDX_CODEC |=> codec_dma_base == $past(reg_bus.wr_data))
    else $error("codec base not stored in full");

  y2r_bytes_a: assert property (
    wr_full && widx == IDX_Y2R_A
      |=> y2r_coef[0] == $past(reg_bus.wr_data[7:0])
          && y2r_coef[3] == $past(reg_bus.wr_data[31:24]))
    else $error("YCrCb to RGB coefficient byte order wrong");

  y2r_c4_a: assert property (
    wr_full && widx == IDX_Y2R_B
      |=> y2r_coef4 == $past(reg_bus.wr_data[8:0])
          && cfg_q[IDX_Y2R_B][11:9] == 3'h0)
    else $error("C4 field width wrong");

  y_offset_a: assert property (
    wr_full && widx == IDX_Y2R_B && reg_bus.wr_data[Y2R_YOFF_BIT]
      |=> ##1 y2r_y_offset == OFS_128)
    else $error("luminance offset not applied");

  chroma_offset_a: assert property (
    wr_full && widx == IDX_Y2R_B
      |=> ##1 y2r_cr_offset == ($past(reg_bus.wr_data[Y2R_CROFF_BIT], 2) ? OFS_16 : OFS_NONE)
          && y2r_cb_offset == ($past(reg_bus.wr_data[Y2R_CBOFF_BIT], 2) ? OFS_16 : OFS_NONE))
    else $error("chrominance offsets wrong");

  r2y_coef_a: assert property (
    wr_full && widx >= IDX_R2Y_A
      |=> r2y_coef[3*($past(widx) - IDX_R2Y_A)] == $past(reg_bus.wr_data[7:0])
          && r2y_coef[3*($past(widx) - IDX_R2Y_A) + 2] == $past(reg_bus.wr_data[23:16]))
    else $error("RGB to YCrCb coefficient placement wrong");

  r_offset_a: assert property (
    r2y_r_offset == ($past(cfg_q[IDX_R2Y_A][R2Y_OFF_BIT]) ? OFS_16 : OFS_NONE))
    else $error("red offset wrong");

  g_offset_a: assert property (
    $rose(cfg_q[IDX_R2Y_B][R2Y_OFF_BIT]) |=> r2y_g_offset == OFS_128 [*2])
    else $error("green offset wrong");

  b_offset_a: assert property (
    $fell(cfg_q[IDX_R2Y_C][R2Y_OFF_BIT]) |=> r2y_b_offset == OFS_NONE)
    else $error("blue offset not removed");

  ptr_wins_a: assert property (
    wr_go && widx == IDX_PREV && preview_ptr_update
      |=> prev_cur_q == preview_queue_start && preview_queue_reload)
    else $error("DMA step beat a pointer write");

  reload_pulse_a: assert property (
    preview_queue_reload |-> $past(wr_go && widx == IDX_PREV))
    else $error("reload pulse without a pointer write");

  bad_write_a: assert property (
    reg_bus.wr_en && !whit
      |=> $stable(codec_dma_base) && $stable(preview_queue_start)
          && $stable(y2r_coef) && !preview_queue_reload)
    else $error("unmapped write changed a register");

  codec_read_a: assert property (
    rhit && ridx == IDX_CODEC |-> reg_bus.rd_data == codec_dma_base)
    else $error("codec base read back wrong");

  y2r_mid_a: assert property (
    wr_full && widx == IDX_Y2R_A
      |=> y2r_coef[1] == $past(reg_bus.wr_data[15:8])
          && y2r_coef[2] == $past(reg_bus.wr_data[23:16]))
    else $error("middle coefficient bytes misplaced");

endmodule

// >>> test_image_csc_dma_config_regs.sv
`timescale 1ns/100ps
module test_image_csc_dma_config_regs
  import icr_pkg::*;
;
  logic             aclk;
  logic             aresetn;
  logic [11:0]      awaddr;
  logic             awvalid;
  logic             awready;
  logic [31:0]      wdata;
  logic [3:0]       wstrb;
  logic             wvalid;
  logic             wready;
  logic [1:0]       bresp;
  logic             bvalid;
  logic             bready;
  logic [11:0]      araddr;
  logic             arvalid;
  logic             arready;
  logic [31:0]      rdata;
  logic [1:0]       rresp;
  logic             rvalid;
  logic             rready;
  logic             ptr_upd;
  logic [31:0]      ptr_next;
  logic [31:0]      preview_queue_start;
  logic             preview_queue_reload;
  logic [31:0]      codec_dma_base;
  logic [3:0][7:0]  y2r_coef;
  logic [8:0]       y2r_coef4;
  logic [7:0]       y_off;
  logic [7:0]       cr_off;
  logic [7:0]       cb_off;
  logic [8:0][7:0]  r2y_coef;
  logic [7:0]       r_off;
  logic [7:0]       g_off;
  logic [7:0]       b_off;
  logic [31:0]      seed = 32'h9E97D611;
  logic [31:0]      mdl[7];
  logic [31:0]      start_m;
  logic [11:0]      bad_addr[4] = '{12'h01C, 12'hFFC, 12'h006, 12'h011};
  int               errors;
  int               tests_run;
  int               reloads;
  int               ptr_wr;

  icr_config_regs i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .preview_ptr_update(ptr_upd), .preview_ptr_next(ptr_next),
    .preview_queue_start(preview_queue_start), .preview_queue_reload(preview_queue_reload),
    .codec_dma_base(codec_dma_base), .y2r_coef(y2r_coef), .y2r_coef4(y2r_coef4),
    .y2r_y_offset(y_off), .y2r_cr_offset(cr_off), .y2r_cb_offset(cb_off),
    .r2y_coef(r2y_coef), .r2y_r_offset(r_off), .r2y_g_offset(g_off), .r2y_b_offset(b_off)
  );

  always #10 aclk = ~aclk;

  // Pulses seen on the reload strobe, compared with accepted pointer writes
  always @(posedge aclk) begin
    if (aresetn && preview_queue_reload === 1'b1) reloads++;
  end

  task automatic wrap_up();
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic hang();
    errors++;
    wrap_up();
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d, logic [3:0] s);
    for (int b = 0; b < 4; b++) if (s[b]) o[8*b +: 8] = d[8*b +: 8];
    return o;
  endfunction

  // Slot 0 holds the pointer as read back; start_m is what the queue restarts from
  function automatic void mdl_wr(int i, logic [31:0] d, logic [3:0] s);
    if (i == 0) begin
      start_m = merge(start_m, d, s) & 32'hFFFFFFFC;
      mdl[0] = start_m;
      ptr_wr++;
    end else if (i == 3) mdl[3] = merge(mdl[3], d, s) & 32'h000071FF;
    else if (i >= 4) mdl[i] = merge(mdl[i], d, s) & 32'h01FFFFFF;
    else mdl[i] = merge(mdl[i], d, s);
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    int n;
    n = 0;
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 64);
    if (bvalid !== 1'b1) hang();
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q, output logic [1:0] r);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 64);
    if (rvalid !== 1'b1) hang();
    q = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Offsets trail the coefficients by a cycle; callers come here well after that
  task automatic outs();
    chk(preview_queue_start, start_m);
    chk(codec_dma_base, mdl[1]);
    chk(y2r_coef, mdl[2]);
    chk({23'h0, y2r_coef4}, {23'h0, mdl[3][8:0]});
    chk({24'h0, y_off}, mdl[3][12] ? 32'h80 : 32'h0);
    chk({24'h0, cr_off}, mdl[3][13] ? 32'h10 : 32'h0);
    chk({24'h0, cb_off}, mdl[3][14] ? 32'h10 : 32'h0);
    chk({8'h00, r2y_coef[2:0]}, {8'h00, mdl[4][23:0]});
    chk({24'h0, r_off}, mdl[4][24] ? 32'h10 : 32'h0);
    chk({8'h00, r2y_coef[5:3]}, {8'h00, mdl[5][23:0]});
    chk({24'h0, g_off}, mdl[5][24] ? 32'h80 : 32'h0);
    chk({8'h00, r2y_coef[8:6]}, {8'h00, mdl[6][23:0]});
    chk({24'h0, b_off}, mdl[6][24] ? 32'h80 : 32'h0);
  endtask

  initial begin
    repeat (100000) @(posedge aclk);
    hang();
  end

  initial begin
    logic [31:0] d;
    logic [31:0] q;
    logic [1:0]  r;
    logic [3:0]  s;
    int          i;
    aclk = 1'b0;
    aresetn = 1'b0;
    awaddr = 12'h000;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 12'h000;
    arvalid = 1'b0;
    rready = 1'b0;
    ptr_upd = 1'b0;
    ptr_next = 32'h0;
    start_m = 32'h0;
    foreach (mdl[k]) mdl[k] = 32'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int k = 0; k < 7; k++) begin
      rd(12'(k * 4), q, r);
      chk(q, 32'h0);
    end
    outs();
    // Each register first with full strobes, then random strobes and targets
    for (int k = 0; k < 48; k++) begin
      i = (k < 14) ? k % 7 : int'(rnd() % 7);
      d = rnd();
      s = (k < 14) ? STRB_ALL : d[7:4] ^ d[27:24];
      if (k == 0) d = 32'hFFFFFFFF;
      wr(12'(i * 4), d, s, r);
      mdl_wr(i, d, s);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      outs();
      rd(12'(i * 4), q, r);
      chk(q, mdl[i]);
    end
    for (int k = 0; k < 8; k++) begin
      d = {17'h0, k[2:0], 12'hFA5};
      wr(OFF_Y2R_B, d, STRB_ALL, r);
      mdl_wr(3, d, STRB_ALL);
      outs();
    end
    // Unmapped and unaligned places must leave every register alone
    foreach (bad_addr[k]) begin
      wr(bad_addr[k], rnd(), STRB_ALL, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      rd(bad_addr[k], q, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      chk(q, 32'h0);
      outs();
    end
    // Two back-to-back DMA advances; the later one is what software sees
    ptr_upd <= 1'b1;
    ptr_next <= rnd();
    @(posedge aclk);
    d = rnd() | 32'h3;
    ptr_next <= d;
    @(posedge aclk);
    ptr_upd <= 1'b0;
    ptr_next <= ~d;
    @(posedge aclk);
    mdl[0] = d & 32'hFFFFFFFC;
    rd(OFF_PREV_PTR, q, r);
    chk(q, mdl[0]);
    outs();
    d = rnd();
    wr(OFF_PREV_PTR, d, 4'h3, r);
    mdl_wr(0, d, 4'h3);
    rd(OFF_PREV_PTR, q, r);
    chk(q, mdl[0]);
    outs();
    // DMA steps on every edge of a pointer write; the write wins only on its own edge
    d = rnd();
    ptr_upd  <= 1'b1;
    ptr_next <= ~d;
    wr(OFF_PREV_PTR, d, STRB_ALL, r);
    mdl_wr(0, d, STRB_ALL);
    ptr_upd  <= 1'b0;
    mdl[0] = ~d & 32'hFFFFFFFC;
    rd(OFF_PREV_PTR, q, r);
    chk(q, mdl[0]);
    outs();
    chk(32'(reloads), 32'(ptr_wr));
    wrap_up();
  end
endmodule
